/* core/sfo_consts.svh */
// Constants for the serial flash erase, ident, OTP and reset sequencer
`ifndef SFO_CONSTS_SVH
`define SFO_CONSTS_SVH
`define SFO_OP_WRITE_ENABLE_COMMAND 8'h06
`define SFO_OP_CHIP_ERASE 8'hC7
`define SFO_OP_MAKER_DEV 8'h90
`define SFO_OP_IDENT 8'h9F
`define SFO_OP_UNIQUE 8'h4B
`define SFO_OP_OTP_ERASE 8'h44
`define SFO_OP_OTP_PROG 8'h42
`define SFO_OP_OTP_READ 8'h48
`define SFO_OP_RST_EN 8'h66
`define SFO_OP_RST 8'h99
`define SFO_AREA_BYTES 1024
`define SFO_OTP_HI 8'h00
`define SFO_OTP_LO10 2'h0
`define SFO_CLK_MHZ 200
`define SFO_T_CE_US 1000
`define SFO_T_SE_US 100
`define SFO_T_PP_US 20
`define SFO_T_RST_US 30
`define SFO_US_CYC(t) ((t) * `SFO_CLK_MHZ)
`endif

/* core/sfo_core.sv */
// Serial flash command sequencer: chip erase, idents, OTP areas, reset
// Notes on behaviour
// - chip erase needs latch, opcode, no address
// - chip erase runs only if frame ends at 8
// - erase busy flag high, latch cleared
// - chip erase only with uniform protect bits
// - maker/device read after zero address
// - ident read gives maker, type, capacity
// - ident read ignored while busy
// - select high ends identification output
// - unique number after address and dummy
// - three 1024-byte areas by address decode
// - area erase ends exactly after address
// - area erase busy flag, latch cleared
// - locked area ignores erase and program
// - area program: latch, address, data bytes
// - area program busy flag, latch cleared
// - area read after address and dummy
// - area read address wraps within area
// - reset restores power-on volatile state
// - commands rejected during reset recovery
`timescale 1ns/100ps
`include "sfo_consts.svh"
module sfo_core #(
    parameter logic [7:0] MAKER_ID = 8'h5A,      // Arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h33,      // Arbitrary value
    parameter logic [7:0] CAPACITY = 8'h16,      // Arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h15,     // Arbitrary value
    parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0011223344556677, // Arbitrary
    parameter int T_CE = `SFO_US_CYC(`SFO_T_CE_US),
    parameter int T_SE = `SFO_US_CYC(`SFO_T_SE_US),
    parameter int T_PP = `SFO_US_CYC(`SFO_T_PP_US),
    parameter int T_RST = `SFO_US_CYC(`SFO_T_RST_US),
    parameter int FIFO_DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    input wire logic [2:0] i_block_protect,
    input wire logic i_protect_complement,
    input wire logic [2:0] i_otp_lock,
    output logic o_write_enable_latch,
    output logic o_write_in_progress_flag,
    output logic o_recovering,
    output logic o_reset_accepted
);
    typedef struct packed {
        sfo_pkg::sfo_phase_type ph;
        sfo_pkg::sfo_cmd_type cmd;
        sfo_pkg::sfo_busy_type busy;
        logic [7:0] sh;
        logic [3:0] bits;
        logic [1:0] abytes;
        logic [23:0] addr;
        logic [7:0] op;
        logic [7:0] nbytes;
        logic [127:0] out;
        logic [9:0] rd_addr;
        logic so;
        logic so_oe;
        logic write_enable_latch;
        logic rst_armed;
        logic [31:0] timer;
        logic [1:0] sel_area;
        logic pp_any;
    } sfo_state_type;
    sfo_state_type s;
    sfo_state_type next_s;
    logic [2:0] cs_sync;
    logic [2:0] ck_sync;
    logic [1:0] si_sync;
    logic [7:0] otp_mem [3*`SFO_AREA_BYTES];
    logic [7:0] rd_byte;
    logic fifo_push;
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop;
    sfo_pkg::sfo_word_type fifo_in;
    sfo_pkg::sfo_word_type fifo_out;
    logic erase_go;
    logic [1:0] erase_area;
    logic [10:0] erase_idx;
    logic [7:0] rx_byte;
    wire cs_low = !cs_sync[1];
    wire cs_rise = cs_sync[1] && !cs_sync[2];
    wire sck_rise = ck_sync[1] && !ck_sync[2] && cs_low;
    wire sck_fall = !ck_sync[1] && ck_sync[2] && cs_low;
    wire busy = s.busy != sfo_pkg::SFO_B_IDLE;
    wire prot_ok = (i_block_protect == 3'h0 && !i_protect_complement)
        || (i_block_protect == 3'h7 && i_protect_complement);
    wire [1:0] a_area = s.addr[13:12];
    wire area_ok = s.addr[23:16] == `SFO_OTP_HI && s.addr[15:14] == 2'h0
        && a_area != 2'h0 && s.addr[11:10] == `SFO_OTP_LO10;
    wire area_locked = i_otp_lock[a_area - 2'h1];
    assign rx_byte = {s.sh[6:0], si_sync[1]};
    // Two-flop synchronisers on the pins, third stage for edges
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cs_sync <= 3'h7;
            ck_sync <= 3'h0;
            si_sync <= 2'h0;
        end else begin
            cs_sync <= {cs_sync[1:0], i_cs_n};
            ck_sync <= {ck_sync[1:0], i_sclk};
            si_sync <= {si_sync[0], i_si};
        end
    end
    assign rd_byte = otp_mem[{s.sel_area - 2'h1, s.rd_addr}];
    // Command decode, shift and busy sequencing
    always_comb begin
        next_s = s;
        fifo_push = 1'b0;
        fifo_in = '0;
        erase_go = 1'b0;
        erase_area = s.sel_area;
        o_reset_accepted = 1'b0;
        if (busy && s.timer != 32'h0) begin
            next_s.timer = s.timer - 32'h1;
        end else if (busy && erase_idx == 11'h0) begin
            // Busy also covers the area sweep, so a new address cannot retarget it
            next_s.busy = sfo_pkg::SFO_B_IDLE;
            next_s.write_enable_latch = 1'b0;
        end
        if (s.busy == sfo_pkg::SFO_B_PROG && !fifo_valid) begin
            next_s.write_enable_latch = 1'b0;
        end
        if (!cs_low) begin
            next_s.so_oe = 1'b0;
        end
        if (sck_rise) begin
            next_s.sh = rx_byte;
            next_s.bits = s.bits + 4'h1;
            unique case (s.ph)
                sfo_pkg::SFO_OPC: begin
                    if (s.bits == 4'h7) begin
                        next_s.op = rx_byte;
                        next_s.bits = 4'h0;
                        next_s.abytes = 2'h0;
                        next_s.ph = sfo_pkg::SFO_SKIP;
                        next_s.cmd = sfo_pkg::SFO_NONE;
                        next_s.nbytes = 8'h0;
                        if (rx_byte != `SFO_OP_RST) begin
                            next_s.rst_armed = 1'b0;
                        end
                        if (s.busy == sfo_pkg::SFO_B_RST) begin
                            next_s.ph = sfo_pkg::SFO_SKIP;
                        end else if (rx_byte == `SFO_OP_IDENT && !busy) begin
                            next_s.cmd = sfo_pkg::SFO_ID;
                            next_s.out = {MAKER_ID, MEM_TYPE, CAPACITY, 104'h0};
                            next_s.ph = sfo_pkg::SFO_DATA;
                        end else if (rx_byte == `SFO_OP_MAKER_DEV && !busy) begin
                            next_s.cmd = sfo_pkg::SFO_MD;
                            next_s.ph = sfo_pkg::SFO_ADDR;
                        end else if (rx_byte == `SFO_OP_UNIQUE && !busy) begin
                            next_s.cmd = sfo_pkg::SFO_UID;
                            next_s.ph = sfo_pkg::SFO_ADDR;
                        end else if (rx_byte == `SFO_OP_OTP_READ && !busy) begin
                            next_s.cmd = sfo_pkg::SFO_RD;
                            next_s.ph = sfo_pkg::SFO_ADDR;
                        end else if (rx_byte == `SFO_OP_OTP_ERASE && !busy) begin
                            next_s.cmd = sfo_pkg::SFO_SE;
                            next_s.ph = sfo_pkg::SFO_ADDR;
                        end else if (rx_byte == `SFO_OP_OTP_PROG && !busy) begin
                            next_s.cmd = sfo_pkg::SFO_PP;
                            next_s.ph = sfo_pkg::SFO_ADDR;
                        end else if (rx_byte == `SFO_OP_CHIP_ERASE && !busy) begin
                            next_s.cmd = sfo_pkg::SFO_CE;
                        end
                    end
                end
                sfo_pkg::SFO_ADDR: begin
                    if (s.bits == 4'h7) begin
                        next_s.bits = 4'h0;
                        next_s.addr = {s.addr[15:0], rx_byte};
                        next_s.abytes = s.abytes + 2'h1;
                        if (s.abytes == 2'h2) begin
                            next_s.sel_area = s.addr[5:4];
                            next_s.rd_addr = {s.addr[1:0], rx_byte};
                            unique case (s.cmd)
                                sfo_pkg::SFO_MD: begin
                                    next_s.ph = sfo_pkg::SFO_DATA;
                                    next_s.out = {MAKER_ID, DEVICE_ID, 112'h0};
                                end
                                sfo_pkg::SFO_UID, sfo_pkg::SFO_RD:
                                    next_s.ph = sfo_pkg::SFO_DUMMY;
                                sfo_pkg::SFO_PP: next_s.ph = sfo_pkg::SFO_DATA;
                                default: next_s.ph = sfo_pkg::SFO_SKIP;
                            endcase
                        end
                    end
                end
                sfo_pkg::SFO_DUMMY: begin
                    if (s.bits == 4'h7) begin
                        next_s.bits = 4'h0;
                        next_s.ph = sfo_pkg::SFO_DATA;
                        next_s.out = {UNIQUE_ID};
                    end
                end
                sfo_pkg::SFO_DATA: begin
                    if (s.bits == 4'h7) begin
                        next_s.bits = 4'h0;
                        if (s.cmd == sfo_pkg::SFO_PP) begin
                            next_s.nbytes = (s.nbytes == 8'hFF) ? s.nbytes : s.nbytes + 8'h1;
                        end
                    end
                end
                default: begin
                    // Saturate so surplus bits never wrap back to exact
                    if (s.bits == 4'hF) begin
                        next_s.bits = s.bits;
                    end
                end
            endcase
        end
        // Output shift on falling edges, MSB first
        if (sck_fall && s.ph == sfo_pkg::SFO_DATA && s.cmd != sfo_pkg::SFO_PP
            && s.bits == 4'h0) begin
            next_s.so_oe = 1'b1;
            if (s.cmd == sfo_pkg::SFO_RD) begin
                next_s.so = rd_byte[7];
                next_s.out = {rd_byte[6:0], 121'h0};
                next_s.rd_addr = s.rd_addr + 10'h1;
            end else begin
                next_s.so = s.out[127];
                next_s.out = {s.out[126:0], 1'b0};
            end
        end else if (sck_fall && s.ph == sfo_pkg::SFO_DATA && s.cmd != sfo_pkg::SFO_PP) begin
            next_s.so = s.out[127];
            next_s.out = {s.out[126:0], 1'b0};
        end
        // Program data byte enters the FIFO when complete
        if (sck_rise && s.ph == sfo_pkg::SFO_DATA && s.cmd == sfo_pkg::SFO_PP
            && s.bits == 4'h7) begin
            fifo_push = area_ok && s.write_enable_latch && !area_locked;
            fifo_in = '{data: rx_byte, addr: s.addr[9:0] + 10'(s.nbytes), area: a_area};
        end
        // Frame end: launch self-timed work if the frame was exact
        if (cs_rise) begin
            next_s.ph = sfo_pkg::SFO_OPC;
            next_s.bits = 4'h0;
            if (s.bits == 4'h0 && s.busy != sfo_pkg::SFO_B_RST) begin
                if (s.ph == sfo_pkg::SFO_SKIP && s.op == `SFO_OP_WRITE_ENABLE_COMMAND && !busy) begin
                    next_s.write_enable_latch = 1'b1;
                end
                if (s.ph == sfo_pkg::SFO_SKIP && s.op == `SFO_OP_RST_EN) begin
                    next_s.rst_armed = 1'b1;
                end
                if (s.ph == sfo_pkg::SFO_SKIP && s.op == `SFO_OP_RST && s.rst_armed) begin
                    o_reset_accepted = 1'b1;
                    next_s = '0;
                    next_s.ph = sfo_pkg::SFO_OPC;
                    next_s.busy = sfo_pkg::SFO_B_RST;
                    next_s.timer = 32'(T_RST);
                end
                if (s.cmd == sfo_pkg::SFO_CE && s.ph == sfo_pkg::SFO_SKIP && s.write_enable_latch && prot_ok) begin
                    next_s.busy = sfo_pkg::SFO_B_ERASE;
                    next_s.timer = 32'(T_CE);
                    erase_go = 1'b1;
                    erase_area = 2'h0;
                end
                if (s.cmd == sfo_pkg::SFO_SE && s.abytes == 2'h3 && s.write_enable_latch && area_ok
                    && !area_locked && s.ph == sfo_pkg::SFO_SKIP) begin
                    next_s.busy = sfo_pkg::SFO_B_ERASE;
                    next_s.timer = 32'(T_SE);
                    erase_go = 1'b1;
                    erase_area = a_area;
                end
                if (s.cmd == sfo_pkg::SFO_PP && s.nbytes != 8'h0 && fifo_valid
                    && s.ph == sfo_pkg::SFO_DATA) begin
                    next_s.busy = sfo_pkg::SFO_B_PROG;
                    next_s.timer = 32'(T_PP);
                end
            end
        end
    end
    // Stale bytes drop only after the frame-end launch decision
    assign fifo_pop = fifo_valid && (s.busy == sfo_pkg::SFO_B_PROG || (!cs_low && !cs_rise));
    // Program data buffer between shifter and OTP array
    sfo_fifo #(.WIDTH($bits(sfo_pkg::sfo_word_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_flush(o_reset_accepted),
        .i_valid(fifo_push),
        .o_ready(fifo_ready),
        .i_data(fifo_in),
        .o_valid(fifo_valid),
        .i_ready(fifo_pop),
        .o_data(fifo_out)
    );
    // OTP array: erase sweep writes all-ones, program only clears bits
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            erase_idx <= 11'h0;
        end else if (o_reset_accepted) begin
            erase_idx <= 11'h0;
        end else if (erase_go && erase_area != 2'h0) begin
            erase_idx <= 11'h400;
        end else if (erase_idx != 11'h0) begin
            erase_idx <= erase_idx + 11'h1;
            otp_mem[{s.sel_area - 2'h1, erase_idx[9:0] - 10'h1}] <= 8'hFF;
            if (erase_idx == 11'h7FF) begin
                erase_idx <= 11'h0;
            end
        end else if (fifo_pop && s.busy == sfo_pkg::SFO_B_PROG && fifo_out.area != 2'h0) begin
            otp_mem[{fifo_out.area - 2'h1, fifo_out.addr}] <=
                otp_mem[{fifo_out.area - 2'h1, fifo_out.addr}] & fifo_out.data;
        end
    end
    // State register
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s <= '0;
            s.ph <= sfo_pkg::SFO_OPC;
        end else begin
            s <= next_s;
        end
    end
    assign o_so = s.so;
    assign o_so_oe = s.so_oe;
    assign o_write_enable_latch = s.write_enable_latch;
    assign o_write_in_progress_flag = s.busy == sfo_pkg::SFO_B_ERASE
        || s.busy == sfo_pkg::SFO_B_PROG;
    assign o_recovering = s.busy == sfo_pkg::SFO_B_RST;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    exact_frame_a: assert property (cs_rise && s.cmd == sfo_pkg::SFO_CE
        && s.bits != 4'h0 |=> !o_write_in_progress_flag || $past(busy))
        else $error("inexact erase frame ran");
    protect_gate_a: assert property (cs_rise && s.cmd == sfo_pkg::SFO_CE
        && !prot_ok && !busy |=> !o_write_in_progress_flag) else $error("protected erase ran");
    wel_gate_a: assert property (!busy && cs_rise && !s.write_enable_latch |=> !o_write_in_progress_flag)
        else $error("erase without latch");
    busy_ends_a: assert property ($fell(o_write_in_progress_flag) |-> !o_write_enable_latch)
        else $error("latch survived cycle");
    ident_busy_a: assert property (busy && sck_rise && s.ph == sfo_pkg::SFO_OPC
        |=> s.cmd != sfo_pkg::SFO_ID) else $error("ident decoded while busy");
    release_so_a: assert property (!cs_low |=> !o_so_oe) else $error("output held");
    wrap_a: assert property (sck_fall && s.cmd == sfo_pkg::SFO_RD
        && s.ph == sfo_pkg::SFO_DATA && s.bits == 4'h0 && s.rd_addr == 10'h3FF
        |=> s.rd_addr == 10'h000) else $error("area address not wrapped");
    reset_arm_a: assert property (o_reset_accepted |-> s.rst_armed)
        else $error("reset without enable");
    recovery_a: assert property (o_reset_accepted |=> o_recovering [*2])
        else $error("recovery missing");
    reset_clear_a: assert property (o_reset_accepted |=> !o_write_enable_latch)
        else $error("latch kept through reset");
    lock_a: assert property (cs_rise && s.cmd == sfo_pkg::SFO_PP && area_locked && !busy
        |=> !o_write_in_progress_flag) else $error("locked area programmed");
    cover_erase_c: cover property (cs_rise ##1 o_write_in_progress_flag);
    cover_reset_c: cover property (o_reset_accepted);
    cover_read_c: cover property (o_so_oe && s.cmd == sfo_pkg::SFO_RD);
endmodule : sfo_core

/* core/sfo_fifo.sv */
// Small valid/ready FIFO for program data
`timescale 1ns/100ps
module sfo_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_flush,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;
    // Full and empty from pointer compare
    assign o_ready = (wp - rp) != (AW+1)'(DEPTH);
    assign o_valid = wp != rp;
    assign o_data = mem[rp[AW-1:0]];
    // Pointer and storage update
    always_ff @(posedge i_clk) begin
        if (!i_resetn || i_flush) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
        end
        if (push) begin
            mem[wp[AW-1:0]] <= i_data;
        end
    end
endmodule : sfo_fifo

/* core/sfo_pkg.sv */
// Types for the serial flash erase, ident, OTP and reset sequencer
package sfo_pkg;
    typedef enum logic [2:0] {
        SFO_IDLE, SFO_OPC, SFO_ADDR, SFO_DUMMY, SFO_DATA, SFO_SKIP
    } sfo_phase_type;
    typedef enum logic [2:0] {
        SFO_NONE, SFO_CE, SFO_MD, SFO_ID, SFO_UID, SFO_SE, SFO_PP, SFO_RD
    } sfo_cmd_type;
    typedef enum logic [1:0] {SFO_B_IDLE, SFO_B_ERASE, SFO_B_PROG, SFO_B_RST} sfo_busy_type;
    typedef struct packed {
        logic [7:0] data;
        logic [9:0] addr;
        logic [1:0] area;
    } sfo_word_type;
endpackage : sfo_pkg

/* dv/sfo_host.sv */
// Host model: drives select, serial clock and data in, gathers data out
`timescale 1ns/100ps
module sfo_host (
    input wire logic i_clk,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_si,
    input wire logic i_so
);
    logic [7:0] rx[$];
    // Idle: deselected, clock parked low
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
    end
    // One bit: data set while clock low, both sides sample at the rise
    task automatic bit_io(input logic v, output logic s);
        o_si <= v;
        repeat (16) @(posedge i_clk);
        s = i_so;
        o_sclk <= 1'b1;
        repeat (16) @(posedge i_clk);
        o_sclk <= 1'b0;
    endtask : bit_io
    // One select frame: send the bytes, read nrd bytes, then extra one-bits
    task automatic frame(input logic [7:0] tx[$], input int nrd, input int extra);
        logic [7:0] b;
        rx = {};
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        repeat (16) @(posedge i_clk);
        foreach (tx[i]) for (int k = 7; k >= 0; k--) bit_io(tx[i][k], b[0]);
        for (int n = 0; n < nrd; n++) begin
            for (int k = 7; k >= 0; k--) bit_io(~o_si, b[k]);
            rx.push_back(b);
        end
        repeat (extra) bit_io(1'b1, b[0]);
        repeat (16) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        repeat (40) @(posedge i_clk);
    endtask : frame
endmodule : sfo_host

/* dv/testbench.sv */
// Self-checking bench for the serial flash command sequencer
`timescale 1ns/100ps
module testbench;
    localparam int T_CE = 1200;
    localparam int T_SP = 300;
    localparam int T_RS = 600;
    localparam logic [31:0] IDS = 32'hA1_42_17_0C;
    localparam logic [127:0] UID = 128'hFEDCBA98765432100123456789ABCDEF;
    logic i_clk, i_resetn, cs_n, sclk, si, so, so_oe, cmp, write_enable_latch, write_in_progress_flag, rec, rst_acc;
    logic [2:0] bp, lock;
    logic [7:0] fq[$];
    logic [7:0] d[4];
    int n_errors, comparisons, seed, n_base;
    int n_rst = 0;
    int n_oe = 0;
    // Released output shows the inverse of its last value
    sfo_host host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si),
        .i_so(so_oe ? so : ~so));
    sfo_core #(.MAKER_ID(IDS[31:24]), .MEM_TYPE(IDS[23:16]), .CAPACITY(IDS[15:8]),
        .DEVICE_ID(IDS[7:0]), .UNIQUE_ID(UID), .T_CE(T_CE), .T_SE(T_SP), .T_PP(T_SP),
        .T_RST(T_RS)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_block_protect(bp),
        .i_protect_complement(cmp), .i_otp_lock(lock), .o_write_enable_latch(write_enable_latch),
        .o_write_in_progress_flag(write_in_progress_flag), .o_recovering(rec), .o_reset_accepted(rst_acc));
    // Clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Counts output-enable cycles and reset pulses
    always @(posedge i_clk) begin
        if (so_oe === 1'b1) n_oe++;
        if (rst_acc === 1'b1) n_rst++;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic write_enable_command;
        host.frame('{8'h06}, 0, 0);
        chk("wel_set", 1, write_enable_latch);
    endtask : write_enable_command
    task automatic wait_idle;
        for (int n = 0; n < 5000 && write_in_progress_flag !== 1'b0; n++) @(posedge i_clk);
        chk("wip_done", 0, write_in_progress_flag);
        chk("wel_clear", 0, write_enable_latch);
    endtask : wait_idle
    function automatic logic ce_runs(input int p);
        return p == 0 || p == 15;
    endfunction : ce_runs
    // Watchdog
    initial begin
        repeat (100000) @(posedge i_clk);
        n_errors++;
        end_sim();
    end
    // Main sequence
    initial begin
        {i_resetn, cmp, bp, lock} = '0;
        {n_errors, comparisons, n_base} = '0;
        seed = 33;
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_clk);
        // Whole-array erase across every protect setting
        for (int p = 0; p < 16; p++) begin
            bp <= 3'(p);
            cmp <= p[3];
            write_enable_command();
            host.frame('{8'hC7}, 0, 0);
            chk("ce_busy", ce_runs(p), write_in_progress_flag);
            if (ce_runs(p)) wait_idle();
            else chk("wel_kept", 1, write_enable_latch);
        end
        host.frame('{8'hC7}, 0, 0);
        chk("ce_nolatch", 0, write_in_progress_flag);
        write_enable_command();
        host.frame('{8'hC7}, 0, 1);
        chk("ce_inexact", 0, write_in_progress_flag);
        write_enable_command();
        host.frame('{8'hC7}, 0, 0);
        n_base = n_oe;
        host.frame('{8'h9F}, 3, 0);
        chk("id_ignored", 0, n_oe - n_base);
        chk("ce_going", 1, write_in_progress_flag);
        wait_idle();
        $display("test erase done");
        // Identification reads
        host.frame('{8'h9F}, 3, 0);
        for (int i = 0; i < 3; i++) chk("ident", IDS[31-8*i -: 8], host.rx[i]);
        host.frame('{8'h9F}, 1, 0);
        chk("ident_cut", IDS[31:24], host.rx[0]);
        chk("oe_off", 0, so_oe);
        host.frame('{8'h90, 8'h00, 8'h00, 8'h00}, 2, 0);
        chk("maker", IDS[31:24], host.rx[0]);
        chk("device", IDS[7:0], host.rx[1]);
        host.frame('{8'h4B, 8'h00, 8'h00, 8'h00, 8'h00}, 16, 0);
        for (int i = 0; i < 16; i++) chk("unique", UID[127-8*i -: 8], host.rx[i]);
        $display("test ident done");
        // Security areas: erase, program across the wrap, read back
        write_enable_command();
        host.frame('{8'h44, 8'h00, 8'h10, 8'h00}, 0, 0);
        chk("se_busy", 1, write_in_progress_flag);
        wait_idle();
        foreach (d[i]) d[i] = 8'($random(seed));
        write_enable_command();
        host.frame('{8'h42, 8'h00, 8'h13, 8'hFE, d[0], d[1], d[2], d[3]}, 0, 0);
        chk("pp_busy", 1, write_in_progress_flag);
        wait_idle();
        host.frame('{8'h48, 8'h00, 8'h13, 8'hFE, 8'h00}, 5, 0);
        for (int i = 0; i < 4; i++) chk("area_rd", d[i], host.rx[i]);
        chk("area_erased", 8'hFF, host.rx[4]);
        lock <= 3'b010;
        write_enable_command();
        host.frame('{8'h44, 8'h00, 8'h20, 8'h00}, 0, 0);
        chk("se_locked", 0, write_in_progress_flag);
        host.frame('{8'h42, 8'h00, 8'h20, 8'h00, d[0]}, 0, 0);
        chk("pp_locked", 0, write_in_progress_flag);
        host.frame('{8'h44, 8'h00, 8'h40, 8'h00}, 0, 0);
        chk("se_badarea", 0, write_in_progress_flag);
        host.frame('{8'h44, 8'h00, 8'h30, 8'h00}, 0, 1);
        chk("se_inexact", 0, write_in_progress_flag);
        chk("wel_held", 1, write_enable_latch);
        $display("test security done");
        // Two-frame reset with the device idle
        chk("idle_first", 0, write_in_progress_flag);
        host.frame('{8'h66}, 0, 0);
        host.frame('{8'h99}, 0, 0);
        chk("rst_seen", 1, n_rst);
        chk("recover", 1, rec);
        chk("wel_reset", 0, write_enable_latch);
        host.frame('{8'h06}, 0, 0);
        chk("refused", 0, write_enable_latch);
        for (int n = 0; n < 2000 && rec !== 1'b0; n++) @(posedge i_clk);
        chk("recovered", 0, rec);
        host.frame('{8'h66}, 0, 0);
        host.frame('{8'h9F}, 0, 0);
        host.frame('{8'h99}, 0, 0);
        chk("rst_cancel", 1, n_rst);
        write_enable_command();
        $display("test reset done");
        // Program past the 8-deep buffer; bytes beyond it are dropped
        host.frame('{8'h44, 8'h00, 8'h30, 8'h00}, 0, 0);
        chk("se3_busy", 1, write_in_progress_flag);
        wait_idle();
        write_enable_command();
        fq = {8'h42, 8'h00, 8'h31, 8'h00};
        for (int i = 0; i < 9; i++) fq.push_back(8'($random(seed)));
        host.frame(fq, 0, 0);
        chk("buf_busy", 1, write_in_progress_flag);
        wait_idle();
        host.frame('{8'h48, 8'h00, 8'h31, 8'h00, 8'h00}, 10, 0);
        for (int i = 0; i < 10; i++) chk("buf_rd", (i < 8) ? fq[i+4] : 8'hFF, host.rx[i]);
        $display("test buffer done");
        end_sim();
    end
endmodule : testbench
